// file: hub_b_err_consts.vh
/*
 * Constants for the link B error logging block: register offsets,
 * field positions, reset values and masks.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef HUB_B_ERR_CONSTS_VH
`define HUB_B_ERR_CONSTS_VH

// Printed offsets (byte addresses on the bus)
`define OFS_FIRST_ERR 8'h80
`define OFS_NEXT_ERR 8'h82
`define OFS_SERR_EN 8'ha0
`define OFS_MGMT_EN 8'ha2
`define OFS_CTRL_EN 8'ha4
`define OFS_IRQ_STAT 8'hb0
`define OFS_IRQ_MASK 8'hb4

// Error flag positions
`define BIT_RX_SERR 6
`define BIT_MABORT 5
`define BIT_TABORT 4
`define BIT_CE_HDR 3
`define BIT_CE_DATA 2
`define BIT_UE_HDR 1
`define BIT_UE_DATA 0

`define ERR_W 7
`define REG_RESET 8'h00
`define LOG_VALID 8'h7f
`define SERR_VALID 8'h3f
`define IRQ_W 3
`define IRQ_VALID 8'h07
`define IRQ_SERR 0
`define IRQ_MGMT 1
`define IRQ_CTRL 2

`endif

// file: err_sync.v
/*
 * Two-flop synchroniser for a bank of level inputs.
 * Assumes inputs are asynchronous to clk.
 */
`timescale 1ns/1ps
module err_sync #(
    parameter W = 7
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_q;

    always @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= {W{1'b0}};
            q <= {W{1'b0}};
        end
        else if (ce)
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// file: msg_gen.v
/*
 * Turns flag/enable pairs into a one-cycle message pulse on the rise
 * of any enabled flag. Assumes flags and enables are synchronous.
 */
`timescale 1ns/1ps
module msg_gen #(
    parameter W = 7
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [W-1:0] flags,
    input wire [W-1:0] enables,
    output reg pulse
);
    reg [W-1:0] prev_q;
    wire [W-1:0] active;

    assign active = flags & enables;

    always @(posedge clk)
    begin
        if (rst)
        begin
            prev_q <= {W{1'b0}};
            pulse <= 1'b0;
        end
        else if (ce)
        begin
            prev_q <= active;
            pulse <= |(active & ~prev_q);
        end
    end
endmodule

// file: hub_b_error_reporting.v
/*
 * Link B error logging and message routing with an Avalon-MM slave.
 * Assumes error inputs are asynchronous levels or pulses held for at
 * least one clk cycle; one clock domain; synchronous active-high reset.
 */
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`include "hub_b_err_consts.vh"

//Contract
// - Next-error log records all later errors
// - Flags clear only on write one
// - Received system error sets bit six
// - Invalid address master abort sets bit five
// - Target abort on own cycle sets four
// - Correctable header/data errors set three, two
// - Uncorrectable header/data errors set one, zero
// - System error enables bits five to zero
// - Received system error never makes system error
// - Management interrupt enables bits six to zero
// - Control interrupt enables bits six to zero
// - First-error log holds only first error
module hub_b_error_reporting (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire err_rx_serr,
    input wire err_mabort,
    input wire err_tabort,
    input wire err_ce_hdr,
    input wire err_ce_data,
    input wire err_ue_hdr,
    input wire err_ue_data,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    output reg avs_response_err,
    output wire system_error,
    output wire management_interrupt,
    output wire control_interrupt,
    output wire irq
);
    wire [`ERR_W-1:0] err_raw;
    wire [`ERR_W-1:0] err_s;
    reg [`ERR_W-1:0] err_prev_q;
    wire [`ERR_W-1:0] err_evt;

    reg [7:0] first_q;
    reg [7:0] next_q;
    reg [7:0] serr_en_q;
    reg [7:0] mgmt_en_q;
    reg [7:0] ctrl_en_q;
    reg [7:0] irq_stat_q;
    reg [7:0] irq_mask_q;

    reg ack_q;
    wire wr_go;
    wire rd_go;
    wire [7:0] wbyte;
    wire [`ERR_W-1:0] logged;
    wire [`IRQ_W-1:0] msg_pulse;

    // Byte address decode helper
    function is_reg;
        input [7:0] a;
        input [7:0] ofs;
        begin
            is_reg = (a == ofs);
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = is_reg(a, `OFS_FIRST_ERR) | is_reg(a, `OFS_NEXT_ERR)
                | is_reg(a, `OFS_SERR_EN) | is_reg(a, `OFS_MGMT_EN)
                | is_reg(a, `OFS_CTRL_EN) | is_reg(a, `OFS_IRQ_STAT)
                | is_reg(a, `OFS_IRQ_MASK);
        end
    endfunction

    assign err_raw[`BIT_RX_SERR] = err_rx_serr;
    assign err_raw[`BIT_MABORT] = err_mabort;
    assign err_raw[`BIT_TABORT] = err_tabort;
    assign err_raw[`BIT_CE_HDR] = err_ce_hdr;
    assign err_raw[`BIT_CE_DATA] = err_ce_data;
    assign err_raw[`BIT_UE_HDR] = err_ue_hdr;
    assign err_raw[`BIT_UE_DATA] = err_ue_data;

    err_sync #(
        .W(`ERR_W)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d(err_raw),
        .q(err_s)
    );

    // Rising edge of a synchronised error level is one event
    always @(posedge clk)
    begin
        if (rst)
            err_prev_q <= {`ERR_W{1'b0}};
        else if (ce)
            err_prev_q <= err_s;
    end

    assign err_evt = err_s & ~err_prev_q;

    // Bus: one wait cycle, answer at the second edge
    assign wr_go = ce & avs_write & ack_q;
    assign rd_go = ce & avs_read & ack_q;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wbyte = avs_byteenable[0] ? avs_writedata[7:0] : `REG_RESET;

    always @(posedge clk)
    begin
        if (rst)
            ack_q <= 1'b0;
        else if (ce)
            ack_q <= (avs_read | avs_write) & ~ack_q;
    end

    // First/next error capture
    reg [7:0] first_d;
    reg [7:0] next_d;
    reg [7:0] first_clr;
    reg [7:0] next_clr;
    reg [7:0] pick;
    integer i;

    always @*
    begin
        first_clr = `REG_RESET;
        next_clr = `REG_RESET;
        if (wr_go && is_reg(avs_address, `OFS_FIRST_ERR))
            first_clr = wbyte;
        if (wr_go && is_reg(avs_address, `OFS_NEXT_ERR))
            next_clr = wbyte;
        // Lowest pending event is the one the first log keeps
        pick = `REG_RESET;
        for (i = `ERR_W - 1; i >= 0; i = i - 1)
        begin
            if (err_evt[i])
                pick = 8'h01 << i;
        end
        first_d = first_q & ~first_clr;
        next_d = next_q & ~next_clr;
        if (first_q == `REG_RESET)
        begin
            first_d = pick;
            next_d = next_d | ({1'b0, err_evt} & ~pick);
        end
        else
        begin
            // Set wins over clear for later events
            next_d = next_d | {1'b0, err_evt};
        end
        first_d = first_d & `LOG_VALID;
        next_d = next_d & `LOG_VALID;
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            first_q <= `REG_RESET;
            next_q <= `REG_RESET;
        end
        else if (ce)
        begin
            first_q <= first_d;
            next_q <= next_d;
        end
    end

    // Enable masks
    always @(posedge clk)
    begin
        if (rst)
        begin
            serr_en_q <= `REG_RESET;
            mgmt_en_q <= `REG_RESET;
            ctrl_en_q <= `REG_RESET;
            irq_mask_q <= `REG_RESET;
        end
        else if (wr_go)
        begin
            if (is_reg(avs_address, `OFS_SERR_EN) && avs_byteenable[0])
                serr_en_q <= wbyte & `SERR_VALID;
            if (is_reg(avs_address, `OFS_MGMT_EN) && avs_byteenable[0])
                mgmt_en_q <= wbyte & `LOG_VALID;
            if (is_reg(avs_address, `OFS_CTRL_EN) && avs_byteenable[0])
                ctrl_en_q <= wbyte & `LOG_VALID;
            if (is_reg(avs_address, `OFS_IRQ_MASK) && avs_byteenable[0])
                irq_mask_q <= wbyte & `IRQ_VALID;
        end
    end

    assign logged = first_q[`ERR_W-1:0] | next_q[`ERR_W-1:0];

    // Message generators, one per message type
    wire [`ERR_W-1:0] en_bank [0:`IRQ_W-1];
    assign en_bank[`IRQ_SERR] = serr_en_q[`ERR_W-1:0];
    assign en_bank[`IRQ_MGMT] = mgmt_en_q[`ERR_W-1:0];
    assign en_bank[`IRQ_CTRL] = ctrl_en_q[`ERR_W-1:0];

    genvar g;
    generate
        for (g = 0; g < `IRQ_W; g = g + 1)
        begin : gen_msg
            msg_gen #(
                .W(`ERR_W)
            ) u_msg (
                .clk(clk),
                .rst(rst),
                .ce(ce),
                .flags(logged),
                .enables(en_bank[g]),
                .pulse(msg_pulse[g])
            );
        end
    endgenerate

    assign system_error = msg_pulse[`IRQ_SERR];
    assign management_interrupt = msg_pulse[`IRQ_MGMT];
    assign control_interrupt = msg_pulse[`IRQ_CTRL];

    // Sticky message status, write one to clear, set wins
    reg [7:0] stat_clr;
    always @*
    begin
        stat_clr = `REG_RESET;
        if (wr_go && is_reg(avs_address, `OFS_IRQ_STAT))
            stat_clr = wbyte;
    end

    always @(posedge clk)
    begin
        if (rst)
            irq_stat_q <= `REG_RESET;
        else if (ce)
            irq_stat_q <= ((irq_stat_q & ~stat_clr)
                | {5'h00, msg_pulse}) & `IRQ_VALID;
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // Read data and error response
    always @(posedge clk)
    begin
        if (rst)
        begin
            avs_readdata <= 32'h0000_0000;
            avs_response_err <= 1'b0;
        end
        else if (ce)
        begin
            avs_response_err <= 1'b0;
            if ((avs_read | avs_write) && !ack_q)
            begin
                avs_response_err <= ~mapped(avs_address);
                avs_readdata <= 32'h0000_0000;
                case (avs_address)
                    `OFS_FIRST_ERR: avs_readdata[7:0] <= first_q;
                    `OFS_NEXT_ERR: avs_readdata[7:0] <= next_q;
                    `OFS_SERR_EN: avs_readdata[7:0] <= serr_en_q;
                    `OFS_MGMT_EN: avs_readdata[7:0] <= mgmt_en_q;
                    `OFS_CTRL_EN: avs_readdata[7:0] <= ctrl_en_q;
                    `OFS_IRQ_STAT: avs_readdata[7:0] <= irq_stat_q;
                    `OFS_IRQ_MASK: avs_readdata[7:0] <= irq_mask_q;
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// file: hub_b_link_model.sv
/* Link B receive side model: turns a one-cycle fire mask into error
   levels held for four cycles. Assumes the bench pulses fire. */
`timescale 1ns/1ps
module hub_b_link_model (
    input wire clk,
    input wire [6:0] fire,
    output reg [6:0] err
);
reg [1:0] hold_q = 2'd0;
initial err = 7'h00;
// Levels held past one edge so each event is one rise
always @(posedge clk)
begin
    if (|fire)
    begin
        err <= fire;
        hold_q <= 2'd3;
    end
    else if (hold_q != 2'd0)
        hold_q <= hold_q - 2'd1;
    else
        err <= 7'h00;
end
endmodule

// file: hub_b_error_reporting_sva.sv
/* Port checker for the link B error block.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`include "hub_b_err_consts.vh"
module hub_b_err_sva (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire avs_response_err,
    input wire system_error,
    input wire management_interrupt,
    input wire control_interrupt,
    input wire irq
);
wire req = avs_read | avs_write;
wire rdone = avs_read & ~avs_waitrequest;
wire mapped = avs_address == `OFS_FIRST_ERR
    || avs_address == `OFS_NEXT_ERR || avs_address == `OFS_SERR_EN
    || avs_address == `OFS_MGMT_EN || avs_address == `OFS_CTRL_EN
    || avs_address == `OFS_IRQ_STAT || avs_address == `OFS_IRQ_MASK;
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
AST_WAIT_FIRST: assert property (ce && $rose(req) |-> avs_waitrequest)
    else $error("waitrequest low on new request");
AST_ANSWER: assert property (ce && req && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait cycle");
AST_IDLE: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest without request");
AST_SERR_RSV: assert property (rdone && avs_address == `OFS_SERR_EN
    |-> avs_readdata[7:6] == 2'b00) else $error("serr enable 7:6 set");
AST_LOG_RSV: assert property (rdone && (avs_address == `OFS_NEXT_ERR
    || avs_address == `OFS_FIRST_ERR) |-> avs_readdata[31:7] == 25'h0)
    else $error("log reserved bits set");
AST_UNMAPPED: assert property (rdone && !mapped
    |-> avs_response_err && avs_readdata == 32'h0)
    else $error("unmapped read not refused");
AST_SE_PULSE: assert property (system_error |=> !system_error)
    else $error("system error longer than one cycle");
AST_MI_PULSE: assert property ($rose(management_interrupt)
    |=> $fell(management_interrupt)) else $error("mgmt pulse too long");
AST_CI_PULSE: assert property (control_interrupt |-> ##1 !control_interrupt)
    else $error("ctrl pulse too long");
AST_RESET_QUIET: assert property (disable iff (1'b0) rst |=> !(system_error
    || management_interrupt || control_interrupt || irq))
    else $error("output active in reset");
COV_SE: cover property (system_error);
COV_MI: cover property (management_interrupt);
COV_IRQ: cover property ($rose(irq));
endmodule
bind hub_b_error_reporting hub_b_err_sva i_sva (.clk(clk), .rst(rst),
    .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err),
    .system_error(system_error), .management_interrupt(management_interrupt),
    .control_interrupt(control_interrupt), .irq(irq));

// file: hub_b_error_reporting_tb.sv
/* Self-checking bench for the link B error block.
   Assumes the link model and the checker are compiled alongside. */
`timescale 1ns/1ps
`include "hub_b_err_consts.vh"
module hub_b_error_reporting_tb;
reg clk = 0;
reg rst = 1;
reg rd = 0;
reg wr = 0;
reg [7:0] adr = 0;
reg [31:0] wd = 0;
reg [6:0] fire = 0;
reg [31:0] r;
reg [7:0] m;
reg [7:0] ofs[5] = '{`OFS_FIRST_ERR, `OFS_NEXT_ERR, `OFS_SERR_EN,
    `OFS_MGMT_EN, `OFS_CTRL_EN};
wire [6:0] err;
wire [31:0] rdata;
wire wt, se, mi, ci, irq, rerr;
reg rerr_s = 0;
int num_errors = 0, n_tests = 0, cyc = 0, k, t, j;
int cnt[3], base[3];
always #12.5 clk = ~clk;
hub_b_link_model i_link (.clk(clk), .fire(fire), .err(err));
hub_b_error_reporting i_dut (.clk(clk), .rst(rst), .ce(1'b1),
    .err_rx_serr(err[6]), .err_mabort(err[5]), .err_tabort(err[4]),
    .err_ce_hdr(err[3]), .err_ce_data(err[2]), .err_ue_hdr(err[1]),
    .err_ue_data(err[0]), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'h1),
    .avs_readdata(rdata), .avs_waitrequest(wt), .avs_response_err(rerr),
    .system_error(se), .management_interrupt(mi),
    .control_interrupt(ci), .irq(irq));
always @(posedge clk)
begin
    cyc <= cyc + 1;
    cnt[0] <= cnt[0] + se;
    cnt[1] <= cnt[1] + mi;
    cnt[2] <= cnt[2] + ci;
    if (cyc == 5000)
    begin
        num_errors++;
        final_report;
    end
end
task final_report;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
task chk(input string n, input [31:0] e, input [31:0] g);
    n_tests++;
    if (g !== e)
    begin
        $display("MISMATCH %s exp %h got %h", n, e, g);
        num_errors++;
    end
endtask
task bus(input w, input [7:0] a, input [7:0] d);
    int n;
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= {24'h0, d};
    n = 0;
    do @(posedge clk); while (wt !== 1'b0 && ++n < 40);
    if (n >= 40)
        num_errors++;
    r = rdata;
    rerr_s = rerr;
    rd <= 0;
    wr <= 0;
    @(posedge clk);
endtask
task inject(input [6:0] mk);
    fire <= mk;
    @(posedge clk);
    fire <= 0;
    repeat (10) @(posedge clk);
endtask
function [7:0] en_mask(int i);
    return i == 0 ? 8'h3f : 8'h7f;
endfunction
function int exp_msg(int typ, int sel, int bitn);
    return typ == sel && !(typ == 0 && bitn == 6);
endfunction
initial
begin
    void'($urandom(32'h4a2f3d93));
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    for (k = 0; k < 5; k++)
    begin
        bus(0, ofs[k], 0);
        chk("reset value", 0, r);
        chk("mapped err", 0, rerr_s);
    end
    bus(0, 8'h84, 0);
    chk("unmapped", 0, r);
    chk("unmapped err", 1, rerr_s);
    for (k = 0; k < 3; k++)
    begin
        m = $urandom;
        bus(1, ofs[k+2], m);
        bus(0, ofs[k+2], 0);
        chk("enable", m & en_mask(k), r);
        bus(1, ofs[k+2], 0);
    end
    k = $urandom_range(6);
    inject(7'h1 << k);
    inject(7'h7f);
    bus(0, `OFS_FIRST_ERR, 0);
    chk("first log", 1 << k, r);
    bus(0, `OFS_NEXT_ERR, 0);
    chk("next log", 8'h7f, r);
    bus(1, `OFS_NEXT_ERR, 8'h0f);
    bus(0, `OFS_NEXT_ERR, 0);
    chk("next w1c", 8'h70, r);
    for (k = 0; k < 7; k++)
        for (t = 0; t < 3; t++)
        begin
            m = 8'h1 << k;
            bus(1, `OFS_FIRST_ERR, 8'hff);
            bus(1, `OFS_NEXT_ERR, 8'hff);
            bus(1, ofs[t+2], m);
            base = cnt;
            inject(m[6:0]);
            for (j = 0; j < 3; j++)
                chk("message", exp_msg(j, t, k), cnt[j] - base[j]);
            bus(1, ofs[t+2], 0);
        end
    bus(0, `OFS_IRQ_STAT, 0);
    chk("irq status", 8'h07, r);
    chk("irq masked", 0, irq);
    bus(1, `OFS_IRQ_MASK, 8'h04);
    chk("irq raised", 1, irq);
    bus(1, `OFS_IRQ_STAT, 8'h04);
    chk("irq cleared", 0, irq);
    final_report;
end
endmodule
